//--- pkg/psm_consts.vh
/*
  Constants of the pre-driver edge strength and monitor threshold block:
  register offsets, field positions, reset values, codes and timing.
  Assumes it is included by its bare name and only holds definitions.
*/
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PSM_ADDR_W 9
`define PSM_ADDR_HS_VDS 9'h18a
`define PSM_ADDR_HS_SRC 9'h18b
`define PSM_ADDR_LS_VDS_A 9'h18c
`define PSM_ADDR_LS_VDS_B 9'h18d
`define PSM_ADDR_LS_EDGE 9'h18f

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define PSM_DATA_W 16
`define PSM_EDGE_CODE_W 2
`define PSM_EDGE_FIELD_W 14
`define PSM_EDGE_OFF_SEL_BIT 15
`define PSM_LVL_CODE_W 3
`define PSM_LVL_FIELD_W 15
`define PSM_LS_VDS_B_W 3
`define PSM_LVL_SEL_HS_VDS 2'b00
`define PSM_LVL_SEL_HS_SRC 2'b01
`define PSM_LVL_SEL_LS_VDS 2'b10

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define PSM_EDGE_300 2'b00
`define PSM_EDGE_50 2'b01
`define PSM_EDGE_25 2'b10
`define PSM_EDGE_12P5 2'b11
`define PSM_LVL_LOWEST 3'b000
`define PSM_LVL_HIGHEST 3'b111
`define PSM_RST_EDGE 14'h0000
`define PSM_RST_LVL 15'h0000
`define PSM_RST_LVL_B 3'h0
`define PSM_RST_DATA 16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PSM_CLK_MHZ 50
`define PSM_EDGE_SWITCH_NS 166
`define PSM_EDGE_SWITCH_CYC ((`PSM_EDGE_SWITCH_NS * `PSM_CLK_MHZ) / 1000)

`endif

//--- logic/psm_rst_sync.v
/*
  Reset release synchroniser: two flip-flops on the active-low reset.
  Assumes resetn may drop at any time and rises asynchronously to clk.
*/
module psm_rst_sync (
    input wire clk,
    input wire resetn,
    output wire rst_n_sync
);

    reg stage1_q;
    reg stage2_q;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign rst_n_sync = stage2_q;

endmodule // psm_rst_sync

//--- logic/psm_pin_filter.v
/*
  Three-flop input filter for pins from outside the clock domain.
  A change is taken once the second and third stages agree.
  Assumes rst_n is already synchronised to clk.
*/
module psm_pin_filter #(
    parameter WIDTH = 4
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out
);

    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    reg [WIDTH-1:0] out_q;
    reg [WIDTH-1:0] out_d;
    integer i;

    always @* begin
        out_d = out_q;
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s2_q[i];
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            out_q <= {WIDTH{1'b0}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign pin_out = out_q;

endmodule // psm_pin_filter

//--- logic/psm_predriver_cfg.v
/*
  Pre-driver edge strength and monitor level configuration: register port,
  microcode strobes, low-side safe gating and monitor result qualification.
  Assumes the register port and microcode strobes come from logic on clk,
  and that enables, supply flags and comparator results arrive from pins.
*/
`include "psm_consts.vh"

module psm_predriver_cfg #(
    parameter LS_NUM = 7,
    parameter LS_MON_NUM = 6,
    parameter HS_NUM = 5
) (
    input wire clk,
    input wire resetn,
    input wire reg_wr,
    input wire reg_rd,
    input wire [8:0] reg_addr,
    input wire [15:0] reg_wdata,
    output wire [15:0] reg_rdata,
    output wire reg_wr_refused,
    input wire config_mode_req,
    output wire normal_mode,
    input wire [6:0] force_fast_strobe,
    input wire level_change_strobe,
    input wire [1:0] level_change_sel,
    input wire [2:0] level_change_index,
    input wire [2:0] level_change_code,
    output wire [13:0] ls_on_strength,
    output wire [13:0] ls_off_strength,
    output wire [14:0] hs_vds_level,
    output wire [14:0] hs_src_level,
    output wire [17:0] ls_vds_level,
    input wire drive_en,
    input wire uv_vccp,
    input wire uv_vcc5,
    input wire clock_ok,
    input wire [6:0] ls_in,
    output wire [6:0] ls_gate,
    input wire [4:0] hs_standalone,
    input wire [4:0] hs_gate_req,
    output wire [4:0] hs_gate,
    input wire [1:0] boost_ref_sel,
    input wire [4:0] hs_vds_cmp,
    input wire [1:0] hs_vds_boost_cmp,
    input wire [4:0] hs_src_cmp,
    input wire [5:0] ls_vds_cmp,
    input wire [4:0] hs_supplied,
    input wire [5:0] ls_supplied,
    output wire [4:0] hs_vds_result,
    output wire [4:0] hs_src_result,
    output wire [5:0] ls_vds_result,
    output wire [4:0] hs_result_valid,
    output wire [5:0] ls_result_valid
);

    // ------------------------------------------------------------------
    // Reset and pin filtering
    // ------------------------------------------------------------------
    localparam CTRL_W = 9;
    localparam MON_W = 29;
    localparam ST_NORMAL = 2'b01;
    localparam ST_CONFIG = 2'b10;

    wire rst_n;
    wire [CTRL_W-1:0] ctrl_f;
    wire [MON_W-1:0] mon_f;

    psm_rst_sync u_rst (
        .clk(clk),
        .resetn(resetn),
        .rst_n_sync(rst_n)
    );

    psm_pin_filter #(
        .WIDTH(CTRL_W)
    ) u_ctrl_filter (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in({hs_standalone, drive_en, uv_vccp, uv_vcc5, clock_ok}),
        .pin_out(ctrl_f)
    );

    psm_pin_filter #(
        .WIDTH(MON_W)
    ) u_mon_filter (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in({ls_supplied, hs_supplied, ls_vds_cmp, hs_src_cmp, hs_vds_boost_cmp,
                 hs_vds_cmp}),
        .pin_out(mon_f)
    );

    wire clock_ok_f = ctrl_f[0];
    wire uv_vcc5_f = ctrl_f[1];
    wire uv_vccp_f = ctrl_f[2];
    wire drive_en_f = ctrl_f[3];
    wire [4:0] standalone_f = ctrl_f[8:4];
    wire [4:0] hs_vds_cmp_f = mon_f[4:0];
    wire [1:0] hs_boost_cmp_f = mon_f[6:5];
    wire [4:0] hs_src_cmp_f = mon_f[11:7];
    wire [5:0] ls_vds_cmp_f = mon_f[17:12];
    wire [4:0] hs_supplied_f = mon_f[22:18];
    wire [5:0] ls_supplied_f = mon_f[28:23];

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function [14:0] put_level;
        input [14:0] word;
        input [2:0] idx;
        input [2:0] code;
        reg [14:0] w;
        begin
            w = word;
            case (idx)
                3'd0: w[2:0] = code;
                3'd1: w[5:3] = code;
                3'd2: w[8:6] = code;
                3'd3: w[11:9] = code;
                3'd4: w[14:12] = code;
                default: w = word;
            endcase
            put_level = w;
        end
    endfunction

    function [13:0] apply_force;
        input [13:0] codes;
        input [6:0] forced;
        integer k;
        reg [13:0] c;
        begin
            c = codes;
            for (k = 0; k < 7; k = k + 1) begin
                if (forced[k]) begin
                    c[2*k +: 2] = `PSM_EDGE_300;
                end
            end
            apply_force = c;
        end
    endfunction

    // ------------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------------
    reg [1:0] mode_q;
    reg [1:0] mode_d;

    always @* begin
        mode_d = mode_q;
        case (mode_q)
            ST_NORMAL: begin
                if (config_mode_req) begin
                    mode_d = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (!config_mode_req) begin
                    mode_d = ST_NORMAL;
                end
            end
            default: mode_d = ST_NORMAL;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= ST_NORMAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    assign normal_mode = mode_q[0];

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    wire wr_edge = reg_wr && (reg_addr == `PSM_ADDR_LS_EDGE);
    wire wr_edge_ok = wr_edge && normal_mode;
    wire wr_off_only = reg_wdata[`PSM_EDGE_OFF_SEL_BIT];
    wire wr_hs_vds = reg_wr && (reg_addr == `PSM_ADDR_HS_VDS);
    wire wr_hs_src = reg_wr && (reg_addr == `PSM_ADDR_HS_SRC);
    wire wr_ls_a = reg_wr && (reg_addr == `PSM_ADDR_LS_VDS_A);
    wire wr_ls_b = reg_wr && (reg_addr == `PSM_ADDR_LS_VDS_B);

    assign reg_wr_refused = wr_edge && !normal_mode;

    // ------------------------------------------------------------------
    // Edge strength registers
    // ------------------------------------------------------------------
    reg [13:0] on_code_q;
    reg [13:0] on_code_d;
    reg [13:0] off_code_q;
    reg [13:0] off_code_d;
    reg [6:0] forced_q;
    reg [6:0] forced_d;
    reg [13:0] on_out_q;
    reg [13:0] off_out_q;

    always @* begin
        on_code_d = on_code_q;
        off_code_d = off_code_q;
        forced_d = forced_q;
        if (wr_edge_ok) begin
            if (wr_off_only) begin
                off_code_d = reg_wdata[`PSM_EDGE_FIELD_W-1:0];
            end else begin
                on_code_d = reg_wdata[`PSM_EDGE_FIELD_W-1:0];
                off_code_d = reg_wdata[`PSM_EDGE_FIELD_W-1:0];
            end
            forced_d = 7'h00;
        end
        // A strobe in the same cycle as the register write still wins.
        forced_d = forced_d | force_fast_strobe;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_code_q <= `PSM_RST_EDGE;
            off_code_q <= `PSM_RST_EDGE;
            forced_q <= 7'h00;
            on_out_q <= `PSM_RST_EDGE;
            off_out_q <= `PSM_RST_EDGE;
        end else begin
            on_code_q <= on_code_d;
            off_code_q <= off_code_d;
            forced_q <= forced_d;
            // Outputs follow the next values so any change lands in one clock.
            on_out_q <= apply_force(on_code_d, forced_d);
            off_out_q <= apply_force(off_code_d, forced_d);
        end
    end

    assign ls_on_strength = on_out_q;
    assign ls_off_strength = off_out_q;

    // ------------------------------------------------------------------
    // Monitor level registers
    // ------------------------------------------------------------------
    reg [14:0] hs_vds_q;
    reg [14:0] hs_vds_d;
    reg [14:0] hs_src_q;
    reg [14:0] hs_src_d;
    reg [14:0] ls_a_q;
    reg [14:0] ls_a_d;
    reg [2:0] ls_b_q;
    reg [2:0] ls_b_d;

    always @* begin
        hs_vds_d = hs_vds_q;
        hs_src_d = hs_src_q;
        ls_a_d = ls_a_q;
        ls_b_d = ls_b_q;
        if (wr_hs_vds) begin
            hs_vds_d = reg_wdata[`PSM_LVL_FIELD_W-1:0];
        end
        if (wr_hs_src) begin
            hs_src_d = reg_wdata[`PSM_LVL_FIELD_W-1:0];
        end
        if (wr_ls_a) begin
            ls_a_d = reg_wdata[`PSM_LVL_FIELD_W-1:0];
        end
        if (wr_ls_b) begin
            ls_b_d = reg_wdata[`PSM_LS_VDS_B_W-1:0];
        end
        // Microcode is applied last, so it wins over a register write to the same field.
        if (level_change_strobe) begin
            case (level_change_sel)
                `PSM_LVL_SEL_HS_VDS: begin
                    hs_vds_d = put_level(hs_vds_d, level_change_index, level_change_code);
                end
                `PSM_LVL_SEL_HS_SRC: begin
                    hs_src_d = put_level(hs_src_d, level_change_index, level_change_code);
                end
                `PSM_LVL_SEL_LS_VDS: begin
                    if (level_change_index == 3'd5) begin
                        ls_b_d = level_change_code;
                    end else begin
                        ls_a_d = put_level(ls_a_d, level_change_index, level_change_code);
                    end
                end
                default: begin
                    hs_vds_d = hs_vds_d;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_vds_q <= `PSM_RST_LVL;
            hs_src_q <= `PSM_RST_LVL;
            ls_a_q <= `PSM_RST_LVL;
            ls_b_q <= `PSM_RST_LVL_B;
        end else begin
            hs_vds_q <= hs_vds_d;
            hs_src_q <= hs_src_d;
            ls_a_q <= ls_a_d;
            ls_b_q <= ls_b_d;
        end
    end

    assign hs_vds_level = hs_vds_q;
    assign hs_src_level = hs_src_q;
    assign ls_vds_level = {ls_b_q, ls_a_q};

    // ------------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------------
    reg [15:0] rdata_q;
    reg [15:0] rdata_d;

    always @* begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            if (reg_addr == `PSM_ADDR_HS_VDS) begin
                rdata_d = {1'b0, hs_vds_q};
            end else if (reg_addr == `PSM_ADDR_HS_SRC) begin
                rdata_d = {1'b0, hs_src_q};
            end else if (reg_addr == `PSM_ADDR_LS_VDS_A) begin
                rdata_d = {1'b0, ls_a_q};
            end else if (reg_addr == `PSM_ADDR_LS_VDS_B) begin
                rdata_d = {13'h0000, ls_b_q};
            end else if (reg_addr == `PSM_ADDR_LS_EDGE) begin
                rdata_d = {2'b00, on_code_q};
            end else begin
                rdata_d = `PSM_RST_DATA;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= `PSM_RST_DATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Gate safe state
    // ------------------------------------------------------------------
    // The raw reset is used here as well, so the gates drop without a clock.
    wire live = resetn & rst_n;
    wire drive_ok = drive_en_f & ~uv_vccp_f & ~uv_vcc5_f & clock_ok_f;

    assign ls_gate = ls_in & {LS_NUM{drive_ok & live}};
    assign hs_gate = hs_gate_req & ~standalone_f & {HS_NUM{live}};

    // ------------------------------------------------------------------
    // Monitor results
    // ------------------------------------------------------------------
    reg [4:0] hs_vds_res_q;
    reg [4:0] hs_vds_res_d;
    reg [4:0] hs_src_res_q;
    reg [5:0] ls_vds_res_q;
    reg [4:0] hs_valid_q;
    reg [5:0] ls_valid_q;

    always @* begin
        hs_vds_res_d = hs_vds_cmp_f;
        if (boost_ref_sel[0]) begin
            hs_vds_res_d[1] = hs_boost_cmp_f[0];
        end
        if (boost_ref_sel[1]) begin
            hs_vds_res_d[3] = hs_boost_cmp_f[1];
        end
        hs_vds_res_d = hs_vds_res_d & hs_supplied_f;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_vds_res_q <= 5'h00;
            hs_src_res_q <= 5'h00;
            ls_vds_res_q <= 6'h00;
            hs_valid_q <= 5'h00;
            ls_valid_q <= 6'h00;
        end else begin
            // Standalone mode does not touch these paths.
            hs_vds_res_q <= hs_vds_res_d;
            hs_src_res_q <= hs_src_cmp_f & hs_supplied_f;
            ls_vds_res_q <= ls_vds_cmp_f & ls_supplied_f;
            hs_valid_q <= hs_supplied_f;
            ls_valid_q <= ls_supplied_f;
        end
    end

    assign hs_vds_result = hs_vds_res_q;
    assign hs_src_result = hs_src_res_q;
    assign ls_vds_result = ls_vds_res_q;
    assign hs_result_valid = hs_valid_q;
    assign ls_result_valid = ls_valid_q;

endmodule // psm_predriver_cfg

//--- verif/psm_cfg_props.sv
/* Concurrent checks of the edge strength and level block, bound to its top.
   Assumes one clock and the raw active-low reset as the disable condition. */
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module psm_cfg_props (
    input wire clk,
    input wire resetn,
    input wire reg_wr,
    input wire [8:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr_refused,
    input wire normal_mode,
    input wire [6:0] force_fast_strobe,
    input wire level_change_strobe,
    input wire [1:0] level_change_sel,
    input wire [2:0] level_change_index,
    input wire [2:0] level_change_code,
    input wire [13:0] ls_on_strength,
    input wire [13:0] ls_off_strength,
    input wire [14:0] hs_vds_level,
    input wire [17:0] ls_vds_level,
    input wire [6:0] ls_in,
    input wire [6:0] ls_gate,
    input wire [4:0] hs_gate_req,
    input wire [4:0] hs_gate
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [13:0] ff_mask;
    wire wr_edge;
    genvar k;
    for (k = 0; k < 7; k = k + 1) begin : g_mask
        assign ff_mask[2*k+1:2*k] = {2{force_fast_strobe[k]}};
    end
    // A strobe in the write cycle wins, so write checks leave such cycles out.
    assign wr_edge = reg_wr && reg_addr == 9'h18f && normal_mode && force_fast_strobe == 7'h00;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    chk_edge_both: assert property (
        wr_edge && !reg_wdata[15] |=> ls_on_strength == $past(reg_wdata[13:0])
        && ls_off_strength == $past(reg_wdata[13:0])) else $error("edge write lost");
    chk_edge_off_only: assert property (
        wr_edge && reg_wdata[15] |=> ls_off_strength == $past(reg_wdata[13:0])
        && $stable(ls_on_strength)) else $error("off only write wrong");
    chk_force_fast: assert property (
        force_fast_strobe != 7'h00 |=> ((ls_on_strength | ls_off_strength)
        & $past(ff_mask)) == 14'h0000) else $error("force not fastest");
    chk_refuse_flag: assert property (
        reg_wr_refused == (reg_wr && reg_addr == 9'h18f && !normal_mode))
        else $error("refuse flag wrong");
    chk_reset_normal: assert property ($rose(resetn) |-> normal_mode)
        else $error("not normal after reset");
    chk_hs_level_wr: assert property (
        reg_wr && reg_addr == 9'h18a && !level_change_strobe
        |=> hs_vds_level == $past(reg_wdata[14:0])) else $error("hs level write lost");
    chk_ls_level_wr: assert property (
        reg_wr && reg_addr == 9'h18d && !level_change_strobe |=> ls_vds_level[17:15]
        == $past(reg_wdata[2:0]) && $stable(ls_vds_level[14:0])) else $error("ls level");
    chk_level_change: assert property (
        level_change_strobe && level_change_sel == 2'b00 && level_change_index <= 3'h4
        |=> 3'(hs_vds_level >> (3 * $past(level_change_index)))
        == $past(level_change_code)) else $error("level change lost");
    chk_gate_input: assert property ((ls_gate & ~ls_in) == 7'h00)
        else $error("gate without input");
    chk_hs_gate_req: assert property ((hs_gate & ~hs_gate_req) == 5'h00)
        else $error("hs gate without request");
    cov_edge: cover property (wr_edge);
    cov_force: cover property (force_fast_strobe != 7'h00);
    cov_refused: cover property (reg_wr_refused);
endmodule // psm_cfg_props

bind psm_predriver_cfg psm_cfg_props i_props (.*);

//--- verif/psm_host_model.sv
/* Host controller model driving the register port of the block.
   Assumes the testbench calls its tasks one at a time. */
module psm_host_model (
    input wire clk,
    input wire [15:0] reg_rdata,
    input wire reg_wr_refused,
    output logic reg_wr,
    output logic reg_rd,
    output logic [8:0] reg_addr,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end
    // Idle address is inverted after every access, and idle data after a write, so stale values are never trusted.
    task automatic wr(input logic [8:0] a, input logic [15:0] d, output logic refused);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge clk);
        refused = reg_wr_refused;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [8:0] a, output logic [15:0] q);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        q = reg_rdata;
    endtask
endmodule // psm_host_model

//--- verif/testbench.sv
/* Self-checking bench of the edge strength and level block.
   Assumes the checker binds itself and the host model owns the register port. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, resetn, reg_wr, reg_rd, reg_wr_refused, config_mode_req, normal_mode, rf;
    logic level_change_strobe, drive_en, uv_vccp, uv_vcc5, clock_ok;
    logic [8:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic [6:0] force_fast_strobe, ls_in, ls_gate;
    logic [1:0] level_change_sel, boost_ref_sel, hs_vds_boost_cmp;
    logic [2:0] level_change_index, level_change_code;
    logic [13:0] ls_on_strength, ls_off_strength;
    logic [14:0] hs_vds_level, hs_src_level;
    logic [17:0] ls_vds_level;
    logic [4:0] hs_standalone, hs_gate_req, hs_gate, hs_vds_cmp, hs_src_cmp, hs_supplied;
    logic [4:0] hs_vds_result, hs_src_result, hs_result_valid;
    logic [5:0] ls_vds_cmp, ls_supplied, ls_vds_result, ls_result_valid;
    int error_cnt = 0;
    int n_checks = 0;
    typedef struct {logic [8:0] a; logic [15:0] d; logic [15:0] r;} psm_row_t;
    typedef struct {logic [7:0] cmd; logic [8:0] a; logic [15:0] r;} psm_lc_t;
    psm_row_t rows [9] = '{'{9'h18a, 16'hffff, 16'h7fff}, '{9'h18b, 16'hb6db, 16'h36db},
        '{9'h18c, 16'h5555, 16'h5555}, '{9'h18d, 16'hfffe, 16'h0006},
        '{9'h18f, 16'h0000, 16'h0000}, '{9'h18f, 16'h1555, 16'h1555},
        '{9'h18f, 16'h2aaa, 16'h2aaa}, '{9'h18f, 16'h3fff, 16'h3fff},
        '{9'h18e, 16'hffff, 16'h0000}};
    // Command is {select, index, code}; select 11 and out-of-range indices are ignored.
    psm_lc_t lcs [6] = '{'{8'h20, 9'h18a, 16'h0fff}, '{8'h47, 9'h18b, 16'h36df},
        '{8'ha9, 9'h18d, 16'h0001}, '{8'hc0, 9'h18a, 16'h0fff},
        '{8'h28, 9'h18a, 16'h0fff}, '{8'h80, 9'h18c, 16'h5550}};

    psm_predriver_cfg i_dut (.*);
    psm_host_model i_host (.*);

    function automatic logic [15:0] view(input logic [8:0] a);
        case (a)
            9'h18a: view = {1'b0, hs_vds_level};
            9'h18b: view = {1'b0, hs_src_level};
            9'h18c: view = {1'b0, ls_vds_level[14:0]};
            9'h18d: view = {13'h0000, ls_vds_level[17:15]};
            9'h18f: view = {2'b00, ls_off_strength};
            default: view = 16'h0000;
        endcase
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wait_gate(input logic [6:0] e);
        for (int i = 0; i < 20 && ls_gate !== e; i++) begin
            @(posedge clk);
        end
        #1;
        check(ls_gate, e, "gate");
        if (ls_gate !== e) begin
            close_out();
        end
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog", $time);
        close_out();
    end
    initial begin
        {resetn, config_mode_req, force_fast_strobe, level_change_strobe} = '0;
        {level_change_sel, level_change_index, level_change_code, hs_standalone} = '0;
        {boost_ref_sel, hs_vds_cmp, hs_vds_boost_cmp, hs_src_cmp, ls_vds_cmp} = '0;
        {hs_supplied, ls_supplied, uv_vccp, uv_vcc5} = '0;
        {drive_en, clock_ok, ls_in, hs_gate_req} = {2'b11, 7'h7f, 5'h1f};
        repeat (5) @(posedge clk);
        check(ls_gate, 7'h00, "gate in reset");
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            i_host.rd(rows[i].a, q);
            check(q, 16'h0000, "reset value");
        end
        foreach (rows[i]) begin
            i_host.wr(rows[i].a, rows[i].d, rf);
            @(negedge clk);
            check(view(rows[i].a), rows[i].r, "port view");
            i_host.rd(rows[i].a, q);
            check(q, rows[i].r, "readback");
        end
        i_host.wr(9'h18f, 16'h8001, rf);
        @(negedge clk);
        check({ls_on_strength, ls_off_strength}, {14'h3fff, 14'h0001}, "off only");
        @(posedge clk);
        force_fast_strobe <= 7'h41;
        @(posedge clk);
        force_fast_strobe <= 7'h00;
        #1;
        check({ls_on_strength, ls_off_strength}, {14'h0ffc, 14'h0000}, "force");
        repeat (5) @(posedge clk);
        check(ls_on_strength, 14'h0ffc, "force held");
        i_host.wr(9'h18f, 16'h1555, rf);
        @(negedge clk);
        check({ls_on_strength, ls_off_strength}, {14'h1555, 14'h1555}, "unforce");
        @(posedge clk);
        config_mode_req <= 1'b1;
        repeat (2) @(posedge clk);
        i_host.wr(9'h18f, 16'h3fff, rf);
        @(negedge clk);
        check({rf, normal_mode, ls_on_strength}, {2'b10, 14'h1555}, "refused");
        @(posedge clk);
        config_mode_req <= 1'b0;
        foreach (lcs[i]) begin
            @(posedge clk);
            level_change_strobe <= 1'b1;
            {level_change_sel, level_change_index, level_change_code} <= lcs[i].cmd;
            @(posedge clk);
            level_change_strobe <= 1'b0;
            i_host.rd(lcs[i].a, q);
            check(q, lcs[i].r, "level change");
        end
        wait_gate(7'h7f);
        @(posedge clk);
        ls_in <= 7'h55;
        wait_gate(7'h55);
        foreach (lcs[i]) begin
            if (i < 4) begin
                @(posedge clk);
                {drive_en, uv_vccp, uv_vcc5, clock_ok} <= 4'h9 ^ (4'h8 >> i);
                wait_gate(7'h00);
                @(posedge clk);
                {drive_en, uv_vccp, uv_vcc5, clock_ok} <= 4'h9;
                wait_gate(7'h55);
            end
        end
        @(posedge clk);
        resetn <= 1'b0;
        #1;
        check(ls_gate, 7'h00, "gate at reset");
        repeat (5) @(posedge clk);
        check({normal_mode, ls_on_strength, hs_vds_level}, {1'b1, 29'h0}, "rereset");
        resetn <= 1'b1;
        {hs_supplied, ls_supplied, hs_vds_cmp, hs_src_cmp} <= {11'h7ff, 5'h15, 5'h0a};
        {ls_vds_cmp, hs_gate_req, hs_vds_boost_cmp} <= {6'h2d, 5'h00, 2'b11};
        repeat (10) @(posedge clk);
        check({hs_vds_result, hs_src_result, ls_vds_result, hs_result_valid, ls_result_valid},
            {5'h15, 5'h0a, 6'h2d, 5'h1f, 6'h3f}, "monitors idle");
        {boost_ref_sel, hs_gate_req} <= {2'b11, 5'h1f};
        repeat (10) @(posedge clk);
        check({hs_gate, hs_vds_result}, {5'h1f, 5'h1f}, "boost ref");
        hs_standalone <= 5'h1f;
        ls_supplied <= 6'h00;
        repeat (10) @(posedge clk);
        check({hs_gate, hs_vds_result, hs_result_valid}, {5'h0, 5'h1f, 5'h1f}, "alone");
        check({ls_vds_result, ls_result_valid}, 12'h000, "unsupplied");
        close_out();
    end
endmodule // testbench
